//--- src/iwf_flags.sv
/*
 internal wakeup source flag register of the low-leakage wakeup unit,
 with enable, exit-mode record and interrupt status/mask, on apb.
 assumes presetn is the chip reset that excludes very-low-leakage wake;
 other reset kinds never reach this block.
*/
`timescale 1ns/100ps
module iwf_flags import iwf_pkg::*; #(
   parameter int N = IWF_SRC_COUNT
) (
   input wire logic pclk, // apb clock, 100 MHz
   input wire logic presetn, // chip reset not vll, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [11:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   input wire logic [3:0] pstrb, // apb byte strobes
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error
   input wire logic [N-1:0] module_wakeup_flag, // peripherals' own flags
   input wire logic [1:0] stop_mode, // current iwf_mode_t
   output logic [N-1:0] module_wakeup_bit, // registered flags
   output logic wake_irq_req, // interrupt-flow request, lls exit
   output logic wake_rst_req, // reset-flow request, very_low_leakage_stop_mode exit
   output logic irq // level interrupt
);
   typedef struct packed {
      logic [N-1:0] flags;
      logic [N-1:0] enable;
      logic [N-1:0] status;
      logic [N-1:0] mask;
      logic [1:0] exit_kind;
      logic irq_req;
      logic rst_req;
      logic [31:0] rdata;
      logic ready;
      logic err;
      logic irq;
   } iwf_state_t;
   iwf_state_t st, next_st;

   logic [N-1:0] synced;
   logic [N-1:0] qualified;
   logic access;
   logic mapped;
   logic rd_status;

   iwf_sync #(.WIDTH(N)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(module_wakeup_flag),
      .sync_out(synced)
   );

   assign qualified = synced & st.enable;
   assign access = psel && penable && !st.ready;
   assign mapped = (paddr == iwf_addr(IWF_OFF_FLAGS)) || (paddr == IWF_OFF_ENABLE)
                   || (paddr == IWF_OFF_STATUS) || (paddr == IWF_OFF_MASK)
                   || (paddr == IWF_OFF_EXIT);
   assign rd_status = access && !pwrite && (paddr == IWF_OFF_STATUS);

   always_comb begin
      logic [N-1:0] rises;
      rises = qualified & ~st.flags;
      next_st = st;
      next_st.irq_req = 1'b0;
      next_st.rst_req = 1'b0;
      next_st.ready = 1'b0;
      next_st.err = 1'b0;
      // cleared when peripheral drops it or its enable bit is cleared
      next_st.flags = qualified;
      if (|rises) begin
         if (stop_mode == IWF_MODE_LLS) begin
            next_st.irq_req = 1'b1;
            next_st.exit_kind = 2'b01 << IWF_EXIT_LLS_POS;
         end
         if (stop_mode == IWF_MODE_VERY_LOW_LEAKAGE_STOP_MODE) begin
            next_st.rst_req = 1'b1;
            next_st.exit_kind = 2'b01 << IWF_EXIT_VERY_LOW_LEAKAGE_STOP_MODE_POS;
         end
      end
      if (access) begin
         next_st.ready = 1'b1;
         next_st.err = !mapped;
         next_st.rdata = '0;
         if (!pwrite) begin
            unique case (paddr)
               iwf_addr(IWF_OFF_FLAGS): next_st.rdata[N-1:0] = st.flags;
               IWF_OFF_ENABLE: next_st.rdata[N-1:0] = st.enable;
               IWF_OFF_STATUS: next_st.rdata[N-1:0] = st.status;
               IWF_OFF_MASK: next_st.rdata[N-1:0] = st.mask;
               IWF_OFF_EXIT: next_st.rdata[1:0] = st.exit_kind;
               default: next_st.rdata = '0;
            endcase
         end else if (pstrb[0]) begin
            if (paddr == IWF_OFF_ENABLE) begin
               next_st.enable = pwdata[N-1:0];
            end
            if (paddr == IWF_OFF_MASK) begin
               next_st.mask = pwdata[N-1:0];
            end
         end
      end
      // read clears status; a new event in the same cycle wins
      if (rd_status) begin
         next_st.status = rises;
      end else begin
         next_st.status = st.status | rises;
      end
      next_st.irq = |(next_st.status & next_st.mask);
   end

   // only chip reset not vll clears
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign prdata = st.rdata;
   assign pready = st.ready;
   assign pslverr = st.err;
   assign module_wakeup_bit = st.flags;
   assign wake_irq_req = st.irq_req;
   assign wake_rst_req = st.rst_req;
   assign irq = st.irq;

   AST_WRITE_NO_EFFECT: assert property (@(posedge pclk) disable iff (!presetn)
      (access && pwrite && paddr == iwf_addr(IWF_OFF_FLAGS) && synced == $past(synced))
      |=> st.flags == $past(st.flags))
      else $error("flag write changed a bit");

   AST_ENABLE_GATES: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1
      |=> (st.flags & ~$past(st.enable)) == '0)
      else $error("disabled source set");

   AST_MIRROR: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1
      |=> st.flags == $past(synced & st.enable))
      else $error("flag not mirrored");

   AST_CLEAR_FOLLOWS: assert property (@(posedge pclk) disable iff (!presetn)
      (st.flags[0] && !synced[0])
      |=> !st.flags[0])
      else $error("bit 0 stuck");

   AST_LLS_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
      (|(qualified & ~st.flags) && stop_mode == IWF_MODE_LLS)
      |=> wake_irq_req && !wake_rst_req)
      else $error("lls exit missed interrupt");

   AST_VERY_LOW_LEAKAGE_STOP_MODE_RST: assert property (@(posedge pclk) disable iff (!presetn)
      (|(qualified & ~st.flags) && stop_mode == IWF_MODE_VERY_LOW_LEAKAGE_STOP_MODE)
      |=> wake_rst_req && !wake_irq_req)
      else $error("very_low_leakage_stop_mode exit missed reset");

   AST_READ_VALUE: assert property (@(posedge pclk) disable iff (!presetn)
      (access && !pwrite && paddr == iwf_addr(IWF_OFF_FLAGS))
      |=> pready && prdata == {24'h000000, $past(st.flags)})
      else $error("bad flag read");

   AST_ONE_REG: assert property (@(posedge pclk) disable iff (!presetn)
      (access && paddr == iwf_addr(IWF_OFF_FLAGS))
      |=> !pslverr)
      else $error("flag reg err");

   AST_RESET_ZERO: assert property (@(posedge pclk)
      $rose(presetn)
      |-> st.flags == IWF_FLAGS_RESET && !pready && !irq && !wake_irq_req && !wake_rst_req)
      else $error("not zero at reset");

   AST_READY_AFTER_ACCESS: assert property (@(posedge pclk) disable iff (!presetn)
      access
      |=> pready)
      else $error("no ready after access");

   AST_READY_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
      pready
      |=> !pready)
      else $error("ready held too long");

   AST_NO_READY_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
      !access
      |=> !pready)
      else $error("ready without access");

   AST_ERR_WITH_READY: assert property (@(posedge pclk) disable iff (!presetn)
      pslverr
      |-> pready)
      else $error("error without ready");

   AST_UNMAPPED_ERR: assert property (@(posedge pclk) disable iff (!presetn)
      (access && !mapped)
      |=> pslverr)
      else $error("unmapped without error");

   AST_UNMAPPED_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
      (access && !mapped && !pwrite)
      |=> prdata == '0)
      else $error("unmapped read not zero");

   AST_READ_UPPER_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
      (access && !pwrite && paddr == iwf_addr(IWF_OFF_FLAGS))
      |=> prdata[31:N] == '0)
      else $error("flag read upper bits set");

   AST_RDATA_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      !access
      |=> $stable(prdata))
      else $error("read data moved while idle");

   AST_WRITE_NO_RDATA: assert property (@(posedge pclk) disable iff (!presetn)
      (access && pwrite)
      |=> prdata == '0)
      else $error("write returned data");

   AST_FLAG_WRITE_OK: assert property (@(posedge pclk) disable iff (!presetn)
      (access && pwrite && paddr == iwf_addr(IWF_OFF_FLAGS))
      |=> pready && !pslverr)
      else $error("flag write refused");

   AST_NO_STROBE: assert property (@(posedge pclk) disable iff (!presetn)
      (access && pwrite && !pstrb[0])
      |=> $stable(st.enable) && $stable(st.mask))
      else $error("write without strobe");

   AST_ENABLE_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
      (access && pwrite && pstrb[0] && paddr == IWF_OFF_ENABLE)
      |=> st.enable == $past(pwdata[N-1:0]))
      else $error("enable write lost");

   AST_ENABLE_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      !(access && pwrite && paddr == IWF_OFF_ENABLE)
      |=> $stable(st.enable))
      else $error("enable changed unasked");

   AST_READ_ENABLE: assert property (@(posedge pclk) disable iff (!presetn)
      (access && !pwrite && paddr == IWF_OFF_ENABLE)
      |=> prdata[N-1:0] == $past(st.enable))
      else $error("bad enable read");

   AST_BIT_NEEDS_SOURCE: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1
      |=> (module_wakeup_bit & ~$past(synced)) == '0)
      else $error("bit set without source");

   AST_REQ_EXCLUSIVE: assert property (@(posedge pclk) disable iff (!presetn)
      wake_irq_req
      |-> !wake_rst_req)
      else $error("both flows requested");

   AST_RUN_NO_REQ: assert property (@(posedge pclk) disable iff (!presetn)
      (stop_mode == IWF_MODE_RUN)
      |=> !wake_irq_req && !wake_rst_req)
      else $error("flow requested in run");

   AST_IRQ_NEEDS_LLS: assert property (@(posedge pclk) disable iff (!presetn)
      wake_irq_req
      |-> $past(stop_mode) == IWF_MODE_LLS)
      else $error("interrupt flow outside lls");

   AST_RST_NEEDS_VERY_LOW_LEAKAGE_STOP_MODE: assert property (@(posedge pclk) disable iff (!presetn)
      wake_rst_req
      |-> $past(stop_mode) == IWF_MODE_VERY_LOW_LEAKAGE_STOP_MODE)
      else $error("reset flow outside very_low_leakage_stop_mode");

   AST_EXIT_LLS: assert property (@(posedge pclk) disable iff (!presetn)
      wake_irq_req
      |-> st.exit_kind[IWF_EXIT_LLS_POS] && !st.exit_kind[IWF_EXIT_VERY_LOW_LEAKAGE_STOP_MODE_POS])
      else $error("lls exit not recorded");

   AST_EXIT_VERY_LOW_LEAKAGE_STOP_MODE: assert property (@(posedge pclk) disable iff (!presetn)
      wake_rst_req
      |-> st.exit_kind[IWF_EXIT_VERY_LOW_LEAKAGE_STOP_MODE_POS] && !st.exit_kind[IWF_EXIT_LLS_POS])
      else $error("very_low_leakage_stop_mode exit not recorded");

   AST_EXIT_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      ((qualified & ~st.flags) == '0)
      |=> $stable(st.exit_kind))
      else $error("exit record moved");

   AST_READ_EXIT: assert property (@(posedge pclk) disable iff (!presetn)
      (access && !pwrite && paddr == IWF_OFF_EXIT)
      |=> prdata == {30'h00000000, $past(st.exit_kind)})
      else $error("bad exit read");

   AST_STATUS_CATCH: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1
      |=> (st.status & $past(qualified & ~st.flags)) == $past(qualified & ~st.flags))
      else $error("new source not in status");

   AST_STATUS_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
      !rd_status
      |=> (st.status & $past(st.status)) == $past(st.status))
      else $error("status bit lost");

   AST_STATUS_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
      (rd_status && (qualified & ~st.flags) == '0)
      |=> st.status == '0)
      else $error("status not cleared by read");

   AST_IRQ_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1
      |-> irq == |(st.status & st.mask))
      else $error("interrupt level wrong");
endmodule : iwf_flags

//--- pkg/iwf_pkg.sv
/*
 package for the internal wakeup source flag register: offsets, layouts,
 reset values and enumerations.
 assumes a 32-bit apb slave at 100 MHz.
*/
// Operation
// - one register names the internal wakeup source
// - low-leakage stop exit: source started interrupt
// - very-low-leakage stop exit: source started reset
// - each bit mirrors its peripheral's flag
// - writing one never clears; peripheral clears
// - only chip reset not vll clears it
// - bit n reads one when module n woke
// - set only by enabled, actually-waking sources
package iwf_pkg;
   localparam int IWF_SRC_COUNT = 8;
   localparam logic [11:0] IWF_OFF_FLAGS = 12'h007;
   localparam logic [11:0] IWF_OFF_ENABLE = 12'h010;
   localparam logic [11:0] IWF_OFF_STATUS = 12'h014;
   localparam logic [11:0] IWF_OFF_MASK = 12'h018;
   // kept clear of the flag word at byte 0x01c
   localparam logic [11:0] IWF_OFF_EXIT = 12'h024;
   localparam logic [7:0] IWF_FLAGS_RESET = 8'h00;
   localparam logic [7:0] IWF_ENABLE_RESET = 8'h00;
   localparam logic [7:0] IWF_MASK_RESET = 8'h00;
   localparam int IWF_EXIT_LLS_POS = 0;
   localparam int IWF_EXIT_VERY_LOW_LEAKAGE_STOP_MODE_POS = 1;
   localparam int IWF_SYNC_STAGES = 3;

   typedef enum logic [1:0] {
      IWF_MODE_RUN = 2'b00,
      IWF_MODE_LLS = 2'b01,
      IWF_MODE_VERY_LOW_LEAKAGE_STOP_MODE = 2'b10
   } iwf_mode_t;

   // register index 7 is not word aligned: byte address = 4*index
   function automatic logic [11:0] iwf_addr(input logic [11:0] idx);
      return {idx[9:0], 2'b00};
   endfunction : iwf_addr
endpackage : iwf_pkg

//--- src/iwf_sync.sv
/*
 three-flop synchroniser with agreement filter for a vector of flags.
 assumes inputs come from peripherals on other clocks or pins.
*/
`timescale 1ns/100ps
module iwf_sync import iwf_pkg::*; #(
   parameter int WIDTH = IWF_SRC_COUNT
) (
   input wire logic pclk, // apb clock
   input wire logic presetn, // async reset, active low
   input wire logic [WIDTH-1:0] async_in, // raw flags
   output logic [WIDTH-1:0] sync_out // filtered flags
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] q;
   } iwf_sync_state_t;
   iwf_sync_state_t st, next_st;

   always_comb begin
      next_st = st;
      next_st.s1 = async_in;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      // change counts once second and third stage agree
      for (int i = 0; i < WIDTH; i++) begin
         if (st.s2[i] == st.s3[i]) begin
            next_st.q[i] = st.s3[i];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign sync_out = st.q;
endmodule : iwf_sync

//--- test/test_iwf_flags.sv
/*
 self-checking bench for the internal wakeup flag register, apb driven.
 assumes flags at iwf_addr(IWF_OFF_FLAGS) and a one-wait-state slave.
*/
`timescale 1ns/100ps
module test_iwf_flags import iwf_pkg::*;;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic wake_irq_req, wake_rst_req, irq_seen, rst_seen, serr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic [7:0] module_wakeup_flag, module_wakeup_bit;
   logic [1:0] stop_mode;
   int fail_count = 0, total_checks = 0, cyc = 0;
   iwf_flags uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .module_wakeup_flag(module_wakeup_flag),
      .stop_mode(stop_mode), .module_wakeup_bit(module_wakeup_bit),
      .wake_irq_req(wake_irq_req), .wake_rst_req(wake_rst_req), .irq(irq));
   initial begin
      pclk = 0;
      forever #5 pclk = ~pclk;
   end
   // pulses last one cycle: latch them
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (wake_irq_req === 1'b1) irq_seen <= 1;
      if (wake_rst_req === 1'b1) rst_seen <= 1;
      if (cyc == 3000) begin
         fail_count++;
         print_verdict();
      end
   end
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      // ends once pready is seen; the bench timeout ends a hung wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdata = prdata;
      serr = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb
   task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
      apb(0, a, 0);
      chk(nm, rdata, exp);
   endtask : rd
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask : wait_cyc
   task automatic t_reset();
      rd("flags", iwf_addr(IWF_OFF_FLAGS), 0);
      rd("enable", IWF_OFF_ENABLE, 0);
      rd("exit", IWF_OFF_EXIT, 0);
      apb(0, 12'h020, 0);
      chk("unmapped data", rdata, 0);
      chk("unmapped err", serr, 1);
      $display("reset test done");
   endtask : t_reset
   task automatic t_wake();
      apb(1, IWF_OFF_ENABLE, 32'h0000_00a5);
      stop_mode <= IWF_MODE_LLS;
      module_wakeup_flag <= 8'hff;
      wait_cyc(8);
      chk("bits", module_wakeup_bit, 8'ha5);
      rd("flags", iwf_addr(IWF_OFF_FLAGS), 32'h0000_00a5);
      chk("irq flow", irq_seen, 1);
      chk("no rst flow", rst_seen, 0);
      rd("exit", IWF_OFF_EXIT, 32'h0000_0001);
      apb(1, iwf_addr(IWF_OFF_FLAGS), 32'h0000_00ff);
      rd("flags", iwf_addr(IWF_OFF_FLAGS), 32'h0000_00a5);
      // the flag write did not clear; the peripheral clears by dropping its flag
      module_wakeup_flag <= 8'h05;
      wait_cyc(8);
      rd("flags", iwf_addr(IWF_OFF_FLAGS), 32'h0000_0005);
      $display("wake test done");
   endtask : t_wake
   task automatic t_irq();
      module_wakeup_flag <= 8'h00;
      apb(1, IWF_OFF_ENABLE, 32'h0000_00ff);
      apb(1, IWF_OFF_MASK, 32'h0000_0080);
      wait_cyc(8);
      apb(0, IWF_OFF_STATUS, 0);
      rst_seen <= 0;
      irq_seen <= 0;
      stop_mode <= IWF_MODE_VERY_LOW_LEAKAGE_STOP_MODE;
      module_wakeup_flag <= 8'h81;
      wait_cyc(8);
      chk("irq", irq, 1);
      chk("rst flow", rst_seen, 1);
      chk("no irq flow", irq_seen, 0);
      chk("bits", module_wakeup_bit, 8'h81);
      rd("exit", IWF_OFF_EXIT, 32'h0000_0002);
      rd("status", IWF_OFF_STATUS, 32'h0000_0081);
      rd("status", IWF_OFF_STATUS, 0);
      chk("irq", irq, 0);
      $display("interrupt test done");
   endtask : t_irq
   task automatic t_rst();
      presetn <= 0;
      wait_cyc(2);
      presetn <= 1;
      rd("flags", iwf_addr(IWF_OFF_FLAGS), 0);
      rd("mask", IWF_OFF_MASK, 0);
      $display("reset mid-run test done");
   endtask : t_rst
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : print_verdict
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = 0;
      {module_wakeup_flag, stop_mode, irq_seen, rst_seen} = 0;
      wait_cyc(12);
      presetn <= 1;
      t_reset();
      t_wake();
      t_irq();
      t_rst();
      print_verdict();
   end
endmodule : test_iwf_flags
